// *** hdl/acbg_host.sv ***
// Host-side controller that runs converters over a chosen bus personality
module acbg_host #(
  parameter int unsigned NUM_CONV = 1,
  parameter int unsigned BURST    = acbg_pkg::BURST_LEN
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  // User side
  input  wire acbg_pkg::acbg_mode_e  mode,
  input  wire logic                  run,
  input  wire logic [7:0]            channel,
  output logic                       busy,
  output logic                       sample_valid,
  output logic [7:0]                 sample_data,
  output logic [7:0]                 sample_addr,
  output logic [$clog2(NUM_CONV+1)-1:0] sample_conv,
  output logic                       burst_done,
  // Converter pins
  output logic                       conv_cs_n,
  output logic                       conv_rd_n,
  output logic                       conv_wr_n,
  output logic                       memory_request_n,
  output logic                       io_request_n,
  output logic                       rw_read,
  output logic                       valid_memory_address,
  output logic [7:0]                 addr_high,
  input  wire logic [8*NUM_CONV-1:0] conv_data,
  input  wire logic [NUM_CONV-1:0]   conv_done_n
);
  initial begin
    if (NUM_CONV < 1 || NUM_CONV > 8) $error("acbg_host: NUM_CONV must be 1..8");
    if (BURST < 1 || BURST > 256) $error("acbg_host: BURST must be 1..256");
    if (int'(acbg_pkg::STORE_BASE) + BURST > 256) $error("acbg_host: store addresses overflow 8 bits");
  end

  localparam int CW = $clog2(NUM_CONV + 1);

  typedef enum logic [2:0] {
    ST_IDLE, ST_CLEAR, ST_START, ST_WAIT, ST_READ, ST_NEXT, ST_RELEASE
  } acbg_state_e;

  // Pin synchronisers for interrupt and data
  logic [NUM_CONV-1:0]   done_s1_q;
  logic [NUM_CONV-1:0]   done_s2_q;
  logic [8*NUM_CONV-1:0] data_s1_q;
  logic [8*NUM_CONV-1:0] data_s2_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      done_s1_q <= '1;
      done_s2_q <= '1;
      data_s1_q <= '0;
      data_s2_q <= '0;
    end else begin
      done_s1_q <= conv_done_n;
      done_s2_q <= done_s1_q;
      data_s1_q <= conv_data;
      data_s2_q <= data_s1_q;
    end
  end
  // AND of completions: wait until every converter is done
  wire all_done = ~|done_s2_q;

  acbg_state_e       st_q;
  acbg_state_e       st_d;
  logic [7:0]        cnt_q;
  logic [7:0]        cnt_d;
  logic [CW-1:0]     conv_q;
  logic [CW-1:0]     conv_d;
  logic              first_q;
  logic              first_d;
  logic              cs_q;
  logic              cs_d;
  logic              rd_q;
  logic              rd_d;
  logic              wr_q;
  logic              wr_d;
  logic              val_q;
  logic              val_d;
  logic              fin_q;
  logic              fin_d;
  logic [7:0]        dat_q;
  logic [7:0]        dat_d;
  logic [7:0]        adr_q;
  logic [7:0]        adr_d;
  logic [7:0]        chan_q;
  logic [7:0]        chan_d;
  logic              fire;
  logic              sb_done;
  logic [3:0]        extra;

  // I/O space adds one wait state to each strobe
  assign extra = (mode == acbg_pkg::ACBG_MODE_IOSPACE) ? 4'(acbg_pkg::IO_WAIT_CYC) : 4'h0;

  acbg_strobe #(
    .WIDTH_CYC (acbg_pkg::STROBE_CYC)
  ) u_strobe (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .fire    (fire),
    .extra   (extra),
    .busy    (),
    .done    (sb_done)
  );

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    conv_d  = conv_q;
    first_d = first_q;
    cs_d    = cs_q;
    rd_d    = rd_q;
    wr_d    = wr_q;
    val_d   = 1'b0;
    fin_d   = 1'b0;
    dat_d   = dat_q;
    adr_d   = adr_q;
    chan_d  = chan_q;
    fire    = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (run) begin
          cnt_d  = 8'h00;
          chan_d = channel;
          cs_d   = 1'b1;
          if (first_q && mode != acbg_pkg::ACBG_MODE_ADAPTER) begin
            rd_d = 1'b1;
            fire = 1'b1;
            st_d = ST_CLEAR;
          end else begin
            wr_d = 1'b1;
            fire = 1'b1;
            st_d = ST_START;
          end
        end
      end
      ST_CLEAR: begin
        if (sb_done) begin
          rd_d    = 1'b0;
          first_d = 1'b0;
          wr_d    = 1'b1;
          fire    = 1'b1;
          st_d    = ST_START;
        end
      end
      ST_START: begin
        // All converters share one start strobe
        if (sb_done) begin
          wr_d = 1'b0;
          st_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (all_done) begin
          conv_d = '0;
          rd_d   = 1'b1;
          fire   = 1'b1;
          st_d   = ST_READ;
        end
      end
      ST_READ: begin
        // Data is sampled at strobe end, well after access time
        if (sb_done) begin
          dat_d = data_s2_q[8*conv_q +: 8];
          adr_d = acbg_pkg::STORE_BASE + cnt_q;
          val_d = 1'b1;
          rd_d  = 1'b0;
          st_d  = ST_NEXT;
        end
      end
      ST_NEXT: begin
        if (int'(conv_q) + 1 < NUM_CONV) begin
          conv_d = conv_q + CW'(1);
          rd_d   = 1'b1;
          fire   = 1'b1;
          st_d   = ST_READ;
        end else begin
          // Chip select drops only after the result is in
          cs_d = 1'b0;
          st_d = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (int'(cnt_q) + 1 >= BURST) begin
          fin_d = 1'b1;
          st_d  = ST_IDLE;
        end else begin
          cnt_d = cnt_q + 8'h01;
          cs_d  = 1'b1;
          wr_d  = 1'b1;
          fire  = 1'b1;
          st_d  = ST_START;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 8'h00;
      conv_q  <= '0;
      first_q <= 1'b1;
      cs_q    <= 1'b0;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      val_q   <= 1'b0;
      fin_q   <= 1'b0;
      dat_q   <= 8'h00;
      adr_q   <= 8'h00;
      chan_q  <= acbg_pkg::CHANNEL_RESET;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      conv_q  <= conv_d;
      first_q <= first_d;
      cs_q    <= cs_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      val_q   <= val_d;
      fin_q   <= fin_d;
      dat_q   <= dat_d;
      adr_q   <= adr_d;
      chan_q  <= chan_d;
    end
  end

  // Pin encoding per personality, registered so every output is a flop
  logic pcs_q;
  logic prd_q;
  logic pwr_q;
  logic pmreq_q;
  logic pioreq_q;
  logic prw_q;
  logic pvma_q;
  logic busy_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pcs_q    <= 1'b1;
      prd_q    <= 1'b1;
      pwr_q    <= 1'b1;
      pmreq_q  <= 1'b1;
      pioreq_q <= 1'b1;
      prw_q    <= 1'b1;
      pvma_q   <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      busy_q  <= (st_d != ST_IDLE);
      pmreq_q <= 1'b1;
      case (mode)
        acbg_pkg::ACBG_MODE_IOSPACE: begin
          pioreq_q <= ~(rd_q | wr_q);
          pcs_q    <= ~cs_q;
          prd_q    <= ~rd_q;
          pwr_q    <= ~wr_q;
          prw_q    <= 1'b1;
          pvma_q   <= 1'b0;
        end
        acbg_pkg::ACBG_MODE_MEMMAP: begin
          pioreq_q <= 1'b1;
          pvma_q   <= rd_q | wr_q;
          prw_q    <= ~wr_q;
          // Decoded select stands only while the address is valid
          pcs_q    <= ~(cs_q & (rd_q | wr_q));
          prd_q    <= ~rd_q;
          pwr_q    <= ~wr_q;
        end
        acbg_pkg::ACBG_MODE_ADAPTER: begin
          pioreq_q <= 1'b1;
          pcs_q    <= 1'b0;
          prd_q    <= 1'b0;
          pwr_q    <= ~wr_q;
          prw_q    <= 1'b1;
          pvma_q   <= 1'b0;
        end
        default: begin
          pioreq_q <= 1'b1;
          pcs_q    <= ~cs_q;
          prd_q    <= ~rd_q;
          pwr_q    <= ~wr_q;
          prw_q    <= 1'b1;
          pvma_q   <= 1'b0;
        end
      endcase
    end
  end

  assign conv_cs_n            = pcs_q;
  assign conv_rd_n            = prd_q;
  assign conv_wr_n            = pwr_q;
  assign memory_request_n     = pmreq_q;
  assign io_request_n         = pioreq_q;
  assign rw_read              = prw_q;
  assign valid_memory_address = pvma_q;
  assign addr_high            = chan_q;
  assign busy                 = busy_q;
  assign sample_valid         = val_q;
  assign sample_data          = dat_q;
  assign sample_addr          = adr_q;
  assign sample_conv          = conv_q;
  assign burst_done           = fin_q;
endmodule

// *** hdl/acbg_pkg.sv ***
// Constants shared by the converter bus controller
package acbg_pkg;
  // Bus personalities the controller can imitate
  typedef enum logic [1:0] {
    ACBG_MODE_PORT,
    ACBG_MODE_IOSPACE,
    ACBG_MODE_MEMMAP,
    ACBG_MODE_ADAPTER
  } acbg_mode_e;

  localparam int unsigned CLK_HZ          = 50_000_000;
  // Least strobe width as a time, then in cycles (rounded up)
  localparam int unsigned STROBE_NS       = 200;
  localparam int unsigned STROBE_CYC      = (STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Extra wait state of I/O-space cycles
  localparam int unsigned IO_WAIT_CYC     = 1;
  // Result data valid after read strobe falls (access time)
  localparam int unsigned ACCESS_NS       = 135;
  localparam int unsigned ACCESS_CYC      = (ACCESS_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned BURST_LEN       = 16;
  localparam logic [7:0]  STORE_BASE      = 8'h20;
  localparam logic [7:0]  CHANNEL_RESET   = 8'h00;
endpackage

// *** hdl/acbg_strobe.sv ***
// Timed strobe-width counter with active-high busy and done
module acbg_strobe #(
  parameter int unsigned WIDTH_CYC = 10
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Control
  input  wire logic fire,
  input  wire logic [3:0] extra,
  output logic      busy,
  output logic      done
);
  initial begin
    if (WIDTH_CYC < 1 || WIDTH_CYC > 200) $error("acbg_strobe: WIDTH_CYC out of range");
  end

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       done_d;
  logic       done_q;

  always_comb begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (cnt_q != 8'h00) begin
      cnt_d = cnt_q - 8'h01;
      if (cnt_q == 8'h01) begin
        done_d = 1'b1;
      end
    end else if (fire) begin
      cnt_d = 8'(WIDTH_CYC) + {4'h0, extra};
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q  <= 8'h00;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign busy = (cnt_q != 8'h00);
  assign done = done_q;
endmodule

// *** testbench/acbg_conv_model.sv ***
// Behavioural converter answering the host strobes
module acbg_conv_model (
  input wire logic   sys_clk,
  input wire logic   reset_n,
  input wire logic   slow,
  input wire logic   cs_n,
  input wire logic   rd_n,
  input wire logic   wr_n,
  output logic [7:0] data,
  output logic       done_n
);
  logic [7:0] res_q;
  logic [7:0] cnt_q;
  logic       run_q;
  logic       rd_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      res_q  <= 8'h5a;
      cnt_q  <= 8'h00;
      run_q  <= 1'b0;
      rd_q   <= 1'b0;
      done_n <= 1'b1;
    end else begin
      rd_q <= !cs_n && !rd_n;
      if (!cs_n && !wr_n) begin
        run_q  <= 1'b1;
        cnt_q  <= 8'h00;
        done_n <= 1'b1;
      end else if (run_q) begin
        cnt_q <= cnt_q + 8'h01;
        if (cnt_q == (slow ? 8'hc8 : 8'h06)) begin
          run_q  <= 1'b0;
          done_n <= 1'b0;
          res_q  <= res_q + 8'h3c;
        end
      end
      if (!cs_n && !rd_n && !rd_q) done_n <= 1'b1;
    end
  end
  // Released bus shows the inverse so a late capture cannot pass
  assign data = (!cs_n && !rd_n) ? res_q : ~res_q;
endmodule

// *** testbench/acbg_host_monitor.sv ***
// Pin-level checker for the converter bus controller
module acbg_host_monitor (
  // Clock and reset
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  // Watched ports
  input wire acbg_pkg::acbg_mode_e mode,
  input wire logic                 busy,
  input wire logic                 sample_valid,
  input wire logic [7:0]           sample_addr,
  input wire logic                 conv_cs_n,
  input wire logic                 conv_rd_n,
  input wire logic                 conv_wr_n,
  input wire logic                 memory_request_n,
  input wire logic                 io_request_n,
  input wire logic                 rw_read,
  input wire logic                 valid_memory_address
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic strobe;
  logic is_port;
  logic is_io;
  logic is_mm;
  logic is_ad;
  assign strobe  = !conv_rd_n || !conv_wr_n;
  assign is_port = mode == acbg_pkg::ACBG_MODE_PORT;
  assign is_io   = mode == acbg_pkg::ACBG_MODE_IOSPACE;
  assign is_mm   = mode == acbg_pkg::ACBG_MODE_MEMMAP;
  assign is_ad   = mode == acbg_pkg::ACBG_MODE_ADAPTER;
  a_memory_request_n_idle: assert property (memory_request_n) else $error("memory request low");
  a_io_qualify: assert property (is_io && strobe |-> !io_request_n) else $error("io request missing");
  a_vma_strobe: assert property (is_mm && strobe |-> valid_memory_address && rw_read == conv_wr_n)
    else $error("vma or rw wrong");
  a_read_holds_cs: assert property ($fell(conv_rd_n) && !is_ad |-> !conv_cs_n [*8])
    else $error("cs released in read");
  a_wr_port_width: assert property ($fell(conv_wr_n) && is_port |-> !conv_wr_n [*8] ##1 !conv_wr_n [*3] ##1 conv_wr_n)
    else $error("write width");
  a_wr_io_width: assert property ($fell(conv_wr_n) && is_io |-> !conv_wr_n [*8] ##1 !conv_wr_n [*4] ##1 conv_wr_n)
    else $error("io write width");
  a_adapter_tied: assert property (is_ad && busy && $past(busy, 2) |-> !conv_cs_n && !conv_rd_n)
    else $error("adapter select");
  a_sample_range: assert property (sample_valid |-> sample_addr[7:4] == 4'h2) else $error("store address");
endmodule
bind acbg_host acbg_host_monitor u_mon (.sys_clk, .reset_n, .mode, .busy, .sample_valid, .sample_addr, .conv_cs_n,
  .conv_rd_n, .conv_wr_n, .memory_request_n, .io_request_n, .rw_read, .valid_memory_address);

// *** testbench/adc_cpu_bus_glue_test.sv ***
// Self-checking bench for the converter bus controller
module adc_cpu_bus_glue_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NB = 2;
  logic                 sys_clk, reset_n, run, slow, busy, sample_valid, burst_done;
  logic                 conv_cs_n, conv_rd_n, conv_wr_n, conv_done_n;
  logic [7:0]           channel, conv_data, exp_q, sample_data, sample_addr, addr_high;
  logic [0:0]           sample_conv;
  acbg_pkg::acbg_mode_e mode;
  int                   err_total, n_tests, n_samp, cyc;
  logic                 wr_seen, rd_first;
  acbg_pkg::acbg_mode_e m_tab[5] = '{acbg_pkg::ACBG_MODE_PORT, acbg_pkg::ACBG_MODE_IOSPACE,
    acbg_pkg::ACBG_MODE_MEMMAP, acbg_pkg::ACBG_MODE_ADAPTER, acbg_pkg::ACBG_MODE_PORT};
  logic                 s_tab[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [7:0]           c_tab[5] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'hff};
  acbg_host #(.NUM_CONV(1), .BURST(NB)) uut (.sys_clk, .reset_n, .mode, .run, .channel, .busy, .sample_valid,
    .sample_data, .sample_addr, .sample_conv, .burst_done, .conv_cs_n, .conv_rd_n, .conv_wr_n,
    .memory_request_n(), .io_request_n(), .rw_read(), .valid_memory_address(), .addr_high, .conv_data, .conv_done_n);
  acbg_conv_model conv (.sys_clk, .reset_n, .slow, .cs_n(conv_cs_n), .rd_n(conv_rd_n), .wr_n(conv_wr_n),
    .data(conv_data), .done_n(conv_done_n));
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic test_done();
    $display("Mismatches %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic do_reset();
    reset_n = 1'b0;
    exp_q = 8'h5a;
    repeat (5) @(negedge sys_clk);
    check(conv_cs_n & conv_rd_n & conv_wr_n & !busy, "reset state");
    reset_n = 1'b1;
  endtask
  // Again pulses run mid-burst, which must be ignored
  task automatic burst(input acbg_pkg::acbg_mode_e m, input logic s, input logic [7:0] ch, input logic again);
    int t;
    mode = m;
    slow = s;
    channel = ch;
    run = 1'b1;
    @(negedge sys_clk);
    run = 1'b0;
    n_samp = 0;
    for (t = 0; t < 3000 && burst_done !== 1'b1; t++) begin
      @(negedge sys_clk);
      run = again && t == 30;
    end
    check(n_samp == NB && addr_high === ch, "burst length or channel");
    repeat (3) @(negedge sys_clk);
    check(busy === 1'b0, "run taken while busy");
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      test_done();
    end
  end
  always @(negedge sys_clk) begin
    if (reset_n && sample_valid === 1'b1) begin
      exp_q = exp_q + 8'h3c;
      check(sample_data === exp_q && sample_conv === 1'b0 && sample_addr === 8'h20 + 8'(n_samp), "sample");
      n_samp++;
    end
  end
  // First strobe after reset must be the clearing read
  always @(negedge sys_clk) begin
    if (!reset_n) begin
      wr_seen = 1'b0;
      rd_first = 1'b0;
    end else if (!wr_seen) begin
      if (!conv_wr_n) wr_seen = 1'b1;
      else if (!conv_rd_n && !conv_cs_n) rd_first = 1'b1;
    end
  end
  initial begin
    run = 1'b0;
    slow = 1'b0;
    channel = 8'h00;
    mode = acbg_pkg::ACBG_MODE_PORT;
    err_total = 0;
    n_tests = 0;
    n_samp = 0;
    cyc = 0;
    do_reset();
    for (int i = 0; i < 5; i++) burst(m_tab[i], s_tab[i], c_tab[i], 1'b0);
    burst(acbg_pkg::ACBG_MODE_IOSPACE, 1'b1, 8'h55, 1'b1);
    run = 1'b1;
    @(negedge sys_clk);
    run = 1'b0;
    repeat (40) @(negedge sys_clk);
    do_reset();
    burst(acbg_pkg::ACBG_MODE_MEMMAP, 1'b0, 8'h3c, 1'b0);
    check(rd_first === 1'b1, "no clearing read before first start");
    test_done();
  end
endmodule
